// *** hdl/insn_decode_pkg.sv ***
// Constants and types for the 12-bit instruction decoder
// Notes on behaviour
// - Each instruction arrives as one 12-bit word holding an opcode field and operand fields.
// - Every word is sorted into byte-oriented, bit-oriented or literal and control groups.
// - Byte and bit instructions carry a 5-bit register select naming one of 32 file registers.
// - For byte instructions a destination bit of 0 sends the result to the accumulator, 1 to the file register.
// - Bit instructions carry a 3-bit field naming one bit of the 8-bit selected register.
// - Literal and control instructions yield an 8-bit or 9-bit immediate, by format.
// - Don't-care bits never change decoding; encoders should fill them with 0.
// - An instruction takes one cycle, or two when its test is true or it changes the program counter.
// - One instruction cycle lasts exactly four oscillator periods.
package insn_decode_pkg;

  // ==========================================================
  // Field layout
  localparam int unsigned INSN_W = 12;
  localparam int unsigned FSEL_LSB = 0;
  localparam int unsigned FSEL_W = 5;
  localparam int unsigned DEST_POS = 5;
  localparam int unsigned BITN_LSB = 5;
  localparam int unsigned BITN_W = 3;
  localparam int unsigned LIT8_W = 8;
  localparam int unsigned LIT9_W = 9;

  // ==========================================================
  // Timing
  localparam int unsigned PHASES_PER_CYCLE = 4;
  localparam logic [1:0] PHASE_LAST = 2'h3;
  localparam logic [1:0] PHASE_RESET = 2'h0;

  // ==========================================================
  // Reset values
  localparam logic [11:0] NOP_WORD = 12'h000;

  typedef enum logic [1:0] {
    GRP_BYTE = 2'b00,
    GRP_BIT = 2'b01,
    GRP_LIT = 2'b10
  } insn_group_t;

  typedef enum logic [1:0] {
    LITF_NONE = 2'b00,
    LITF_8 = 2'b01,
    LITF_9 = 2'b10
  } lit_form_t;

endpackage : insn_decode_pkg

// *** hdl/decode_if.sv ***
// Carrier between the field splitter and the timing top
`timescale 1ns/1ps
`default_nettype none
interface decode_if;
  logic [11:0] word;
  insn_decode_pkg::insn_group_t group;
  logic [4:0] fsel;
  logic dest_file;
  logic [2:0] bitn;
  logic [8:0] literal;
  insn_decode_pkg::lit_form_t lit_form;
  logic pc_change;
  logic cond_test;

  modport splitter (input word, output group, fsel, dest_file, bitn, literal, lit_form,
    pc_change, cond_test);
  modport user (output word, input group, fsel, dest_file, bitn, literal, lit_form,
    pc_change, cond_test);
endinterface : decode_if
`default_nettype wire

// *** hdl/insn_field_split.sv ***
// Combinational field splitter for 12-bit instruction words
`timescale 1ns/1ps
`default_nettype none
module insn_field_split
(
  decode_if.splitter dif
);

  // ==========================================================
  // Field extraction
  always_comb
  begin
    dif.fsel = dif.word[insn_decode_pkg::FSEL_LSB +: insn_decode_pkg::FSEL_W];
    dif.dest_file = dif.word[insn_decode_pkg::DEST_POS];
    dif.bitn = dif.word[insn_decode_pkg::BITN_LSB +: insn_decode_pkg::BITN_W];
    dif.literal = 9'h000;
    dif.lit_form = insn_decode_pkg::LITF_NONE;
    dif.pc_change = 1'b0;
    dif.cond_test = 1'b0;
    if (dif.word[11:10] == 2'b00)
    begin
      dif.group = insn_decode_pkg::GRP_BYTE;
      // Skip-on-zero forms test the result
      dif.cond_test = (dif.word[9:6] == 4'hB) || (dif.word[9:6] == 4'hF);
    end
    else if (dif.word[11:10] == 2'b01)
    begin
      dif.group = insn_decode_pkg::GRP_BIT;
      dif.cond_test = dif.word[9];
    end
    else
    begin
      dif.group = insn_decode_pkg::GRP_LIT;
      if (dif.word[11:9] == 3'b101)
      begin
        dif.literal = dif.word[8:0];
        dif.lit_form = insn_decode_pkg::LITF_9;
        dif.pc_change = 1'b1;
      end
      else
      begin
        dif.literal = {1'b0, dif.word[7:0]};
        dif.lit_form = insn_decode_pkg::LITF_8;
        // Return and call alter the counter
        dif.pc_change = (dif.word[11:9] == 3'b100);
      end
    end
    // don't-care bits
    // Zero-page control words are decoded only from defined bits; fields above stay inert.
  end

endmodule : insn_field_split
`default_nettype wire

// *** hdl/insn_decoder.sv ***
// Instruction decoder and four-phase cycle timing
`timescale 1ns/1ps
`default_nettype none
module insn_decoder
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic reset_i,
  // Program memory side
  input wire logic [11:0] insn_i,
  input wire logic cond_true_i,
  // Timing
  output logic [1:0] phase_o,
  output logic cycle_end_o,
  // Decoded fields
  output insn_decode_pkg::insn_group_t group_o,
  output logic [4:0] fsel_o,
  output logic dest_file_o,
  output logic [2:0] bitn_o,
  output logic [8:0] literal_o,
  output insn_decode_pkg::lit_form_t lit_form_o,
  output logic [11:0] word_o,
  output logic flush_o
);

  // ==========================================================
  // State
  typedef struct packed {
    logic [1:0] phase;
    logic flush;
    logic [11:0] word;
    insn_decode_pkg::insn_group_t group;
    logic [4:0] fsel;
    logic dest_file;
    logic [2:0] bitn;
    logic [8:0] literal;
    insn_decode_pkg::lit_form_t lit_form;
    logic cycle_end;
  } state_t;

  state_t state_q;
  state_t state_d;
  logic [11:0] fetch_sync1_q;
  logic [11:0] fetch_sync2_q;
  logic cond_sync1_q;
  logic cond_sync2_q;

  decode_if dif ();

  // Program memory sits outside this clock, so both inputs are synchronised
  always_ff @(posedge clk_i)
  begin
    fetch_sync1_q <= insn_i;
    fetch_sync2_q <= fetch_sync1_q;
    cond_sync1_q <= cond_true_i;
    cond_sync2_q <= cond_sync1_q;
  end

  assign dif.word = state_q.flush ? insn_decode_pkg::NOP_WORD : fetch_sync2_q;

  insn_field_split u_split
  (
    .dif(dif)
  );

  // ==========================================================
  // Next state
  always_comb
  begin
    state_d = state_q;
    state_d.phase = state_q.phase + 2'h1;
    // Pulse lands on phase 0, together with the freshly latched fields
    state_d.cycle_end = (state_q.phase == insn_decode_pkg::PHASE_LAST);
    if (state_q.phase == insn_decode_pkg::PHASE_LAST)
    begin
      state_d.word = dif.word;
      state_d.group = dif.group;
      state_d.fsel = dif.fsel;
      state_d.dest_file = dif.dest_file;
      state_d.bitn = dif.bitn;
      state_d.literal = dif.literal;
      state_d.lit_form = dif.lit_form;
      // second cycle
      // Condition is sampled at the cycle boundary; earlier phases may still settle.
      state_d.flush = dif.pc_change || (dif.cond_test && cond_sync2_q);
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (reset_i)
    begin
      state_q <= '{phase: insn_decode_pkg::PHASE_RESET, flush: 1'b0,
        word: insn_decode_pkg::NOP_WORD, group: insn_decode_pkg::GRP_BYTE,
        fsel: 5'h00, dest_file: 1'b0, bitn: 3'h0, literal: 9'h000,
        lit_form: insn_decode_pkg::LITF_NONE, cycle_end: 1'b0};
    end
    else
    begin
      state_q <= state_d;
    end
  end

  // ==========================================================
  // Outputs
  assign phase_o = state_q.phase;
  assign cycle_end_o = state_q.cycle_end;
  assign group_o = state_q.group;
  assign fsel_o = state_q.fsel;
  assign dest_file_o = state_q.dest_file;
  assign bitn_o = state_q.bitn;
  assign literal_o = state_q.literal;
  assign lit_form_o = state_q.lit_form;
  assign word_o = state_q.word;
  assign flush_o = state_q.flush;

endmodule : insn_decoder
`default_nettype wire

// *** tb/insn_decoder_chk.sv ***
// Port assertions for the instruction decoder
`timescale 1ns/1ps
`default_nettype none
module insn_decoder_chk
(
  // Watched ports
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic [1:0] phase_o,
  input wire logic cycle_end_o,
  input wire insn_decode_pkg::insn_group_t group_o,
  input wire logic [4:0] fsel_o,
  input wire logic dest_file_o,
  input wire logic [2:0] bitn_o,
  input wire logic [8:0] literal_o,
  input wire insn_decode_pkg::lit_form_t lit_form_o,
  input wire logic [11:0] word_o,
  input wire logic flush_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (reset_i);
  sequence seq_walk;
    phase_o == 2'h0 ##1 phase_o == 2'h1 ##1 phase_o == 2'h2 ##1 phase_o == 2'h3;
  endsequence
  a_phase_walk: assert property (phase_o == 2'h3 |=> seq_walk)
    else $error("phase walk broken");
  a_end_pulse: assert property (cycle_end_o |-> phase_o == 2'h0 ##1 !cycle_end_o [*3])
    else $error("cycle end not a phase 0 pulse");
  a_end_wrap: assert property (phase_o == 2'h3 |=> cycle_end_o)
    else $error("no cycle end after wrap");
  a_fields_stand: assert property (!cycle_end_o |-> $stable(word_o) && $stable(literal_o))
    else $error("fields moved inside a cycle");
  a_reg_fields: assert property (fsel_o == word_o[4:0] && bitn_o == word_o[7:5] && dest_file_o == word_o[5])
    else $error("register fields wrong");
  a_group_map: assert property (group_o == {word_o[11], !word_o[11] && word_o[10]})
    else $error("group wrong");
  a_lit_nine: assert property (word_o[11:9] == 3'b101 |-> lit_form_o == insn_decode_pkg::LITF_9 && literal_o == word_o[8:0])
    else $error("nine bit literal wrong");
  a_flush_noop: assert property (flush_o && phase_o == 2'h3 |=> word_o == 12'h000)
    else $error("flushed word not a no-op");
  a_branch_two: assert property (cycle_end_o && word_o[11:10] == 2'b10 |-> flush_o)
    else $error("branch without second cycle");
endmodule : insn_decoder_chk
bind insn_decoder insn_decoder_chk u_chk (.clk_i, .reset_i, .phase_o, .cycle_end_o, .group_o,
  .fsel_o, .dest_file_o, .bitn_o, .literal_o, .lit_form_o, .word_o, .flush_o);
`default_nettype wire

// *** tb/prog_mem_model.sv ***
// Program memory model feeding one word per instruction cycle
`timescale 1ns/1ps
`default_nettype none
module prog_mem_model
(
  // Core timing
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic [1:0] phase_i,
  // Fetched word
  output logic [11:0] insn_o
);
  logic [11:0] rom [64];
  int ptr_q;
  logic seen_q;
  always @(posedge clk_i)
  begin
    if (reset_i)
    begin
      ptr_q <= 0;
      seen_q <= 1'b0;
    end
    else
    begin
      if (phase_i == 2'h3)
        seen_q <= 1'b1;
      if (phase_i == 2'h0 && seen_q)
        ptr_q <= ptr_q + 1;
    end
  end
  // Past the end the memory holds no-ops
  assign insn_o = (ptr_q < 64) ? rom[ptr_q] : 12'h000;
endmodule : prog_mem_model
`default_nettype wire

// *** tb/twelve_bit_instruction_decoder_tb.sv ***
// Self-checking bench for the instruction decoder
`timescale 1ns/1ps
`default_nettype none
module twelve_bit_instruction_decoder_tb;
  logic clk_i = 1'b0;
  logic reset_i = 1'b1;
  logic cond_true_i = 1'b0;
  logic [11:0] insn_i, word_o, w;
  logic [1:0] phase_o;
  logic cycle_end_o, dest_file_o, flush_o, fl;
  insn_decode_pkg::insn_group_t group_o;
  logic [4:0] fsel_o;
  logic [2:0] bitn_o;
  logic [8:0] literal_o;
  insn_decode_pkg::lit_form_t lit_form_o;
  logic [11:0] exp_q [$];
  logic exp_fl_q [$];
  int seed = 32'ha483c4da;
  int mismatches = 0;
  int checked = 0;
  int cycles = 0;
  insn_decoder u_dut (.clk_i, .reset_i, .insn_i, .cond_true_i, .phase_o, .cycle_end_o, .group_o,
    .fsel_o, .dest_file_o, .bitn_o, .literal_o, .lit_form_o, .word_o, .flush_o);
  prog_mem_model u_mem (.clk_i, .reset_i, .phase_i(phase_o), .insn_o(insn_i));
  task automatic chk(input string n, input logic [11:0] e, input logic [11:0] g);
    checked++;
    if (g !== e)
    begin
      mismatches++;
      $display("[ERR] %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  task automatic wrap_up;
    if (exp_q.size() != 0)
      mismatches++;
    $display("checked %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : wrap_up
  initial forever #12.5 clk_i = ~clk_i;
  // Condition flips only between no-op words, so its sampling point is moot
  always @(posedge clk_i) cond_true_i <= (u_mem.ptr_q >= 32);
  // Monitor: one decoded word per cycle end, until a timeout
  always @(posedge clk_i)
  begin
    cycles <= cycles + 1;
    if (cycles == 2000)
    begin
      mismatches++;
      wrap_up();
    end
    if (cycle_end_o === 1'b1 && u_mem.seen_q === 1'b1 && exp_q.size() > 0)
    begin
      w = exp_q.pop_front();
      chk("word", w, word_o);
      chk("group", {10'h000, w[11], !w[11] && w[10]}, 12'(group_o));
      chk("literal", w[11:9] == 3'b101 ? {3'h0, w[8:0]} : (w[11] ? {4'h0, w[7:0]} : 12'h000),
        {3'h0, literal_o});
      chk("fields", {4'h0, w[7:0]}, {4'h0, bitn_o, fsel_o});
      chk("dest", {11'h000, w[5]}, {11'h000, dest_file_o});
      chk("form", w[11:9] == 3'b101 ? 12'h002 : (w[11] ? 12'h001 : 12'h000), 12'(lit_form_o));
      chk("flush", {11'h000, exp_fl_q.pop_front()}, {11'h000, flush_o});
    end
  end
  initial
  begin
    fl = 1'b0;
    for (int i = 0; i < 64; i++)
    begin
      w = (i >= 28 && i < 36) ? 12'h000 : ((i == 1) ? 12'hA5F : 12'($random(seed)));
      u_mem.rom[i] = w;
      w = fl ? 12'h000 : w;
      exp_q.push_back(w);
      // branch or true skip flushes the next word
      fl = w[11:10] == 2'b10 || (i >= 32 && (w[11:9] == 3'b011 || (w[11:9] == 3'b001 && w[7:6] == 2'b11)));
      exp_fl_q.push_back(fl);
    end
    repeat (10) @(posedge clk_i);
    reset_i <= 1'b0;
    repeat (300) @(posedge clk_i);
    wrap_up();
  end
endmodule : twelve_bit_instruction_decoder_tb
`default_nettype wire
